// ==== src/sgc_switch_global_control.sv ====
// Switch global control register with AXI4-Lite access and reset sequencing
//
// Contract
// - Enable bit 15 clear keeps the switch core idle; set makes it active.
// - Register and memory access keeps working while the core is disabled.
// - Bits 14..8 disable ports 6..0; one disables, zero enables.
// - Writing one to bit 1 resets every module and all register settings.
// - Bit 1 reads one during the full reset and clears itself afterwards.
// - Writing one to bit 0 resets the core modules but keeps registers.
// - Logic reset keeps register programming; bit 0 clears itself afterwards.
`timescale 1ns/1ns
module sgc_switch_global_control
#(
    parameter int RESET_HOLD = sgc_pkg::SGC_RESET_HOLD_CYCLES // Core reset length in cycles
)
(
    input wire logic ref_clk, // System clock, 20 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic [sgc_pkg::SGC_ADDR_WIDTH-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [sgc_pkg::SGC_DATA_WIDTH-1:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [sgc_pkg::SGC_ADDR_WIDTH-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [sgc_pkg::SGC_DATA_WIDTH-1:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output logic core_reset, // Switch core modules held in reset
    output logic switch_active, // Core may forward frames
    output logic [sgc_pkg::SGC_PORT_COUNT-1:0] port_enable // Per-port forwarding enable
);
    import sgc_pkg::*;

    // Address decode shared by read and write paths
    function automatic logic is_cfg_addr(input logic [SGC_ADDR_WIDTH-1:0] addr);
        is_cfg_addr = (addr[SGC_ADDR_WIDTH-1:2] == SGC_CFG_OFFSET[SGC_ADDR_WIDTH-1:2]);
    endfunction

    logic aw_held;
    logic w_held;
    logic [SGC_ADDR_WIDTH-1:0] aw_addr;
    logic [SGC_DATA_WIDTH-1:0] w_data;
    logic [3:0] w_strb;
    logic do_write;
    logic wr_hit;
    logic cfg_enable;
    logic [SGC_PORT_COUNT-1:0] cfg_port_dis;
    logic full_reset_request;
    logic logic_reset_request;
    logic [15:0] cfg_word;
    logic [7:0] hold_cnt;
    sgc_state_type state;
    sgc_state_type next_state;
    logic set_full;
    logic set_logic;
    logic next_active;

    // Write channel handshakes, address and data taken in either order
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wr_hit = do_write && is_cfg_addr(aw_addr);
    assign s_axi_arready = !s_axi_rvalid;

    // Register requests arriving from software
    assign set_full = wr_hit && w_strb[0] && w_data[SGC_FULL_RESET_BIT];
    assign set_logic = wr_hit && w_strb[0] && w_data[SGC_LOGIC_RESET_BIT];

    // Readback word, reserved bits forced low
    assign cfg_word = {cfg_enable, cfg_port_dis, 6'h00, full_reset_request, logic_reset_request};

    // Capture of write address and data
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            else if (do_write)
                w_held <= 1'b0;
        end
    end

    // Write response, answered in every sequencer state
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= SGC_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_cfg_addr(aw_addr) ? SGC_RESP_OKAY : SGC_RESP_DECERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read channel, one cycle to data
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= SGC_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            if (is_cfg_addr(s_axi_araddr))
            begin
                s_axi_rdata <= {16'h0000, cfg_word};
                s_axi_rresp <= SGC_RESP_OKAY;
            end
            else
            begin
                s_axi_rdata <= '0;
                s_axi_rresp <= SGC_RESP_DECERR;
            end
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Enable and port disable fields; full reset returns them to defaults
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cfg_enable <= SGC_ENABLE_RESET;
            cfg_port_dis <= SGC_PORT_DIS_RESET;
        end
        else if (state == SGC_FULL_RST)
        begin
            cfg_enable <= SGC_ENABLE_RESET;
            cfg_port_dis <= SGC_PORT_DIS_RESET;
        end
        else if (wr_hit && w_strb[1])
        begin
            cfg_enable <= w_data[SGC_ENABLE_BIT];
            cfg_port_dis <= w_data[SGC_PORT_DIS_LSB +: SGC_PORT_COUNT];
        end
    end

    // Full reset request bit, self clearing; a new write wins over the clear
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            full_reset_request <= 1'b0;
        else if (set_full)
            full_reset_request <= 1'b1;
        else if (state == SGC_FULL_RST && hold_cnt == 8'h00)
            full_reset_request <= 1'b0;
    end

    // Logic reset request bit, self clearing, dropped by a full reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            logic_reset_request <= 1'b0;
        else if (set_logic && state != SGC_FULL_RST)
            logic_reset_request <= 1'b1;
        else if (state == SGC_FULL_RST || (state == SGC_LOGIC_RST && hold_cnt == 8'h00))
            logic_reset_request <= 1'b0;
    end

    // Reset sequencer next state
    always_comb
    begin
        next_state = state;
        unique case (state)
            SGC_IDLE:
            begin
                if (full_reset_request)
                begin
                    next_state = SGC_FULL_RST;
                end
                else if (logic_reset_request)
                begin
                    next_state = SGC_LOGIC_RST;
                end
            end
            SGC_LOGIC_RST:
            begin
                if (full_reset_request)
                begin
                    next_state = SGC_FULL_RST;
                end
                else if (hold_cnt == 8'h00)
                begin
                    next_state = SGC_IDLE;
                end
            end
            SGC_FULL_RST:
            begin
                if (hold_cnt == 8'h00)
                begin
                    next_state = SGC_IDLE;
                end
            end
            default:
            begin
                next_state = SGC_IDLE;
            end
        endcase
    end

    // Sequencer state and hold counter
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= SGC_IDLE;
            hold_cnt <= 8'h00;
        end
        else
        begin
            state <= next_state;
            if (next_state != state)
            begin
                hold_cnt <= 8'(RESET_HOLD - 1);
            end
            else if (hold_cnt != 8'h00)
            begin
                hold_cnt <= hold_cnt - 8'h01;
            end
        end
    end

    // Core gating follows the enable only outside any reset
    assign next_active = cfg_enable && next_state == SGC_IDLE;

    // Registered core controls
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            core_reset <= 1'b0;
            switch_active <= 1'b0;
        end
        else
        begin
            core_reset <= next_state != SGC_IDLE;
            switch_active <= next_active;
        end
    end

    // Per-port enables
    genvar gi;
    generate
        for (gi = 0; gi < SGC_PORT_COUNT; gi++)
        begin : g_port
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                begin
                    port_enable[gi] <= 1'b0;
                end
                else
                begin
                    port_enable[gi] <= next_active && !cfg_port_dis[gi];
                end
            end
        end
    endgenerate

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_core_off: assert property (!cfg_enable |=> !switch_active && port_enable == '0)
        else $error("core active while enable bit clear");
    chk_core_on: assert property (cfg_enable && state == SGC_IDLE && next_state == SGC_IDLE |=> switch_active)
        else $error("core inactive while enabled");
    chk_read_open: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    chk_port_gate: assert property (1'b1 |=> (port_enable & $past(cfg_port_dis)) == '0)
        else $error("disabled port still enabled");
    chk_full_defaults: assert property (state == SGC_IDLE && full_reset_request
        |=> state == SGC_FULL_RST ##1 cfg_enable == SGC_ENABLE_RESET && core_reset)
        else $error("full reset did not restore defaults");
    chk_full_clear: assert property (state == SGC_IDLE && full_reset_request && !set_full
        |=> full_reset_request [*8] ##1 !full_reset_request || RESET_HOLD != 8)
        else $error("full reset bit length wrong");
    chk_logic_start: assert property (state == SGC_IDLE && logic_reset_request && !full_reset_request
        |=> core_reset && state == SGC_LOGIC_RST)
        else $error("logic reset not started");
    chk_logic_keep: assert property (state == SGC_LOGIC_RST && !wr_hit
        |=> cfg_enable == $past(cfg_enable) && cfg_port_dis == $past(cfg_port_dis))
        else $error("logic reset changed settings");
    chk_logic_done: assert property (state == SGC_LOGIC_RST && hold_cnt == 8'h00 && !full_reset_request && !set_logic
        |=> !logic_reset_request && state == SGC_IDLE)
        else $error("logic reset bit not cleared");
    chk_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == '0 && s_axi_rdata[7:2] == '0)
        else $error("reserved bits read nonzero");

    cov_full_reset: cover property (state == SGC_FULL_RST ##1 state == SGC_IDLE);
    cov_logic_reset: cover property (state == SGC_LOGIC_RST ##1 state == SGC_IDLE);
    cov_enable_write: cover property (wr_hit ##1 cfg_enable ##2 switch_active);
    cov_logic_to_full: cover property (state == SGC_LOGIC_RST ##1 state == SGC_FULL_RST);
endmodule

// ==== src/sgc_pkg.sv ====
// Constants and types for the switch global control register block
package sgc_pkg;
    // Bus geometry
    localparam int SGC_ADDR_WIDTH = 16;
    localparam int SGC_DATA_WIDTH = 32;
    localparam int SGC_PORT_COUNT = 7;

    // Register byte address
    localparam logic [15:0] SGC_CFG_OFFSET = 16'hF400;

    // Field positions inside the configuration word
    localparam int SGC_ENABLE_BIT = 15;
    localparam int SGC_PORT_DIS_LSB = 8;
    localparam int SGC_FULL_RESET_BIT = 1;
    localparam int SGC_LOGIC_RESET_BIT = 0;

    // Values after reset
    localparam logic SGC_ENABLE_RESET = 1'b0;
    localparam logic [6:0] SGC_PORT_DIS_RESET = 7'h00;

    // Cycles that the core reset is held for either reset request
    localparam int SGC_RESET_HOLD_CYCLES = 8;

    // AXI response codes
    localparam logic [1:0] SGC_RESP_OKAY = 2'h0;
    localparam logic [1:0] SGC_RESP_DECERR = 2'h3;

    // Reset sequencer states, Gray along idle, logic, full
    typedef enum logic [1:0] {
        SGC_IDLE = 2'h0,
        SGC_LOGIC_RST = 2'h1,
        SGC_FULL_RST = 2'h3
    } sgc_state_type;
endpackage

// ==== verification/tb.sv ====
// Self-checking bench for the switch global control register block
`timescale 1ns/1ns
module tb;
    import sgc_pkg::*;
    localparam logic [15:0] unmapped_addr = 16'hF404;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] s_axi_awaddr = 16'h0000;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [15:0] s_axi_araddr = 16'h0000;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic core_reset;
    logic switch_active;
    logic [6:0] port_enable;
    logic [33:0] exp_read[$];
    logic [1:0] exp_write[$];
    logic [15:0] cfg;
    integer seed = 32'h4C01;
    int fails = 0;
    int compares = 0;
    int cycles = 0;

    sgc_switch_global_control DUT (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .core_reset, .switch_active, .port_enable);

    // Clock of 50 ns period
    always #25 ref_clk = ~ref_clk;

    task automatic note(input string what, input logic [33:0] exp, input logic [33:0] got);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_read(input logic [33:0] exp, input logic [33:0] got);
        note("read response and data", exp, got);
    endtask

    task automatic check_resp(input logic [1:0] exp, input logic [1:0] got);
        note("write response", {32'h00000000, exp}, {32'h00000000, got});
    endtask

    task automatic check_status(input logic [8:0] exp);
        @(negedge ref_clk);
        note("reset, active, port enables", {25'h0000000, exp}, {25'h0000000, core_reset, switch_active, port_enable});
    endtask

    // Expected core status for a field value and reset state
    function automatic logic [8:0] exp_status(input logic [15:0] v, input logic busy);
        logic act;
        act = v[15] & ~busy;
        return {busy, act, act ? ~v[14:8] : 7'h00};
    endfunction

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Write with both channels offered together, then wait for the response
    task automatic axi_write(input logic [15:0] addr, input logic [31:0] data, input logic [3:0] strb,
        input logic [1:0] resp);
        logic aw_hit;
        logic w_hit;
        logic aw_done;
        logic w_done;
        exp_write.push_back(resp);
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge ref_clk);
        s_axi_awaddr <= addr;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= data;
        s_axi_wstrb <= strb;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done))
        begin
            @(negedge ref_clk);
            aw_hit = s_axi_awvalid && s_axi_awready;
            w_hit = s_axi_wvalid && s_axi_wready;
            @(posedge ref_clk);
            if (aw_hit)
            begin
                s_axi_awvalid <= 1'b0;
                aw_done = 1'b1;
            end
            if (w_hit)
            begin
                s_axi_wvalid <= 1'b0;
                w_done = 1'b1;
            end
        end
        s_axi_bready <= 1'b1;
        do
        begin
            @(negedge ref_clk);
            aw_hit = s_axi_bvalid;
            @(posedge ref_clk);
        end
        while (!aw_hit);
        s_axi_bready <= 1'b0;
    endtask

    // Read one word and note the expected response and data
    task automatic axi_read(input logic [15:0] addr, input logic [33:0] exp);
        logic hit;
        exp_read.push_back(exp);
        @(posedge ref_clk);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        do
        begin
            @(negedge ref_clk);
            hit = s_axi_arready;
            @(posedge ref_clk);
        end
        while (!hit);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b1;
        do
        begin
            @(negedge ref_clk);
            hit = s_axi_rvalid;
            @(posedge ref_clk);
        end
        while (!hit);
        s_axi_rready <= 1'b0;
    endtask

    task automatic wait_core_idle;
        for (int k = 0; k < 100; k++)
        begin
            @(negedge ref_clk);
            if (!core_reset)
                break;
        end
    endtask

    // Response watcher takes the oldest note at each completed handshake
    always @(negedge ref_clk)
    begin
        if (s_axi_rvalid && s_axi_rready)
            check_read(exp_read.pop_front(), {s_axi_rresp, s_axi_rdata});
        if (s_axi_bvalid && s_axi_bready)
            check_resp(exp_write.pop_front(), s_axi_bresp);
    end

    // Hang guard
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            fails++;
            give_verdict();
        end
    end

    // Main sequence
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        axi_read(SGC_CFG_OFFSET, {SGC_RESP_OKAY, 32'h00000000});
        $display("test reset value done");
        for (int i = 0; i < 6; i++)
        begin
            cfg = 16'($random(seed)) | 16'h00FC;
            cfg[15] = i[0];
            cfg[1:0] = 2'h0;
            axi_write(SGC_CFG_OFFSET, {16'hFFFF, cfg}, 4'hF, SGC_RESP_OKAY);
            axi_read(SGC_CFG_OFFSET, {SGC_RESP_OKAY, 16'h0000, cfg[15:8], 8'h00});
            check_status(exp_status(cfg, 1'b0));
        end
        cfg[7:0] = 8'h00;
        axi_write(SGC_CFG_OFFSET, 32'h0000FF00, 4'h1, SGC_RESP_OKAY);
        axi_read(SGC_CFG_OFFSET, {SGC_RESP_OKAY, 16'h0000, cfg});
        $display("test field write and read back done");
        axi_write(SGC_CFG_OFFSET, {16'h0000, cfg | 16'h0001}, 4'hF, SGC_RESP_OKAY);
        check_status(exp_status(cfg, 1'b1));
        axi_read(SGC_CFG_OFFSET, {SGC_RESP_OKAY, 16'h0000, cfg | 16'h0001});
        wait_core_idle();
        axi_read(SGC_CFG_OFFSET, {SGC_RESP_OKAY, 16'h0000, cfg});
        check_status(exp_status(cfg, 1'b0));
        $display("test logic reset done");
        axi_write(SGC_CFG_OFFSET, {16'h0000, cfg | 16'h0002}, 4'hF, SGC_RESP_OKAY);
        check_status(exp_status(cfg, 1'b1));
        axi_read(SGC_CFG_OFFSET, {SGC_RESP_OKAY, 32'h00000002});
        wait_core_idle();
        axi_read(SGC_CFG_OFFSET, {SGC_RESP_OKAY, 32'h00000000});
        check_status(exp_status(16'h0000, 1'b0));
        $display("test full reset done");
        axi_write(unmapped_addr, 32'h0000FFFF, 4'hF, SGC_RESP_DECERR);
        axi_read(unmapped_addr, {SGC_RESP_DECERR, 32'h00000000});
        axi_read(SGC_CFG_OFFSET, {SGC_RESP_OKAY, 32'h00000000});
        $display("test unmapped address done");
        repeat (2) @(posedge ref_clk);
        give_verdict();
    end
endmodule
